// file: rtl/ccs_pkg.sv
// constants and types for the clock source switch register block
package ccs_pkg;

	// apb byte addresses of the four registers
	localparam logic [11:0] REQUEST_ADDR = 12'h000;
	localparam logic [11:0] CURRENT_ADDR = 12'h004;
	localparam logic [11:0] CONTROL_ADDR = 12'h008;
	localparam logic [11:0] STATUS_ADDR  = 12'h00c;

	// request and current register layout
	localparam int SOURCE_LSB  = 4;
	localparam int SOURCE_MSB  = 6;
	localparam int DIVIDER_LSB = 0;
	localparam int DIVIDER_MSB = 3;

	// switch control register layout
	localparam int HOLD_BIT     = 7;
	localparam int SEC_PWR_BIT  = 6;
	localparam int DONE_BIT     = 4;
	localparam int NEW_RDY_BIT  = 3;

	// oscillator ready status layout
	localparam int EXT_RDY_BIT = 7;
	localparam int HF_RDY_BIT  = 6;
	localparam int MF_RDY_BIT  = 5;
	localparam int LF_RDY_BIT  = 4;
	localparam int SEC_RDY_BIT = 3;
	localparam int ADC_RDY_BIT = 2;
	localparam int PLL_RDY_BIT = 0;

	// source codes
	localparam logic [2:0] SRC_EXTERNAL  = 3'h7;
	localparam logic [2:0] SRC_HF_INT    = 3'h6;
	localparam logic [2:0] SRC_LF_INT    = 3'h5;
	localparam logic [2:0] SRC_SECONDARY = 3'h4;
	localparam logic [2:0] SRC_RESERVED3 = 3'h3;
	localparam logic [2:0] SRC_EXT_PLL   = 3'h2;
	localparam logic [2:0] SRC_HF_PLL    = 3'h1;
	localparam logic [2:0] SRC_RESERVED0 = 3'h0;

	// divider codes: ratio is two to the code
	localparam logic [3:0] DIV_BY_1     = 4'h0;
	localparam logic [3:0] DIV_BY_4     = 4'h2;
	localparam logic [3:0] DIV_MAX_CODE = 4'h9;

	// reset values of the control register
	localparam logic HOLD_RESET    = 1'b0;
	localparam logic SEC_PWR_RESET = 1'b0;

	// quiet time with the system clock gated during a swap
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int GATE_QUIET_NS   = 80;
	localparam int GATE_QUIET_CYC  = (GATE_QUIET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam logic [3:0] GATE_QUIET_COUNT = 4'(GATE_QUIET_CYC);

	typedef struct packed {
		logic [2:0] source;
		logic [3:0] divider;
	} ccs_sel_type;

	typedef struct packed {
		logic ext_ready;
		logic hf_ready;
		logic mf_ready;
		logic lf_ready;
		logic sec_ready;
		logic adc_ready;
		logic pll_enabled;
		logic pll_locked;
	} ccs_osc_type;

	localparam ccs_sel_type SEL_RESET = '{source: SRC_HF_INT, divider: DIV_BY_1};

endpackage

// file: rtl/ccs_switch_seq.sv
// glitch free swap sequencer for the system clock selection
`timescale 1ns/1ps
module ccs_switch_seq (
	input  wire logic           i_clock,
	input  wire logic           i_rstn,
	input  wire logic           i_load,
	input  ccs_pkg::ccs_sel_type i_load_value,
	input  wire logic           i_start,
	input  ccs_pkg::ccs_sel_type i_target,
	output ccs_pkg::ccs_sel_type o_active,
	output logic                o_gate_enable,
	output logic                o_busy,
	output logic                o_done
);

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_QUIET, SEQ_SWAP, SEQ_RESUME} ccs_seq_type;

	ccs_seq_type          state_reg;
	ccs_seq_type          state_next;
	ccs_pkg::ccs_sel_type active_reg;
	ccs_pkg::ccs_sel_type active_next;
	ccs_pkg::ccs_sel_type target_reg;
	ccs_pkg::ccs_sel_type target_next;
	logic [3:0]           count_reg;
	logic [3:0]           count_next;
	logic                 gate_reg;
	logic                 gate_next;
	logic                 done_reg;
	logic                 done_next;

	always_comb begin
		state_next  = state_reg;
		active_next = active_reg;
		target_next = target_reg;
		count_next  = count_reg;
		gate_next   = gate_reg;
		done_next   = 1'b0;
		unique case (state_reg)
			SEQ_IDLE: begin
				if (i_load) begin
					// clock runs once the fuse selection is in
					active_next = i_load_value;
					gate_next   = 1'b1;
				end else if (i_start) begin
					target_next = i_target;
					gate_next   = 1'b0;
					count_next  = ccs_pkg::GATE_QUIET_COUNT;
					state_next  = SEQ_QUIET;
				end
			end
			SEQ_QUIET: begin
				// old clock must fall silent before the mux moves
				if (count_reg <= 4'h1) begin
					state_next = SEQ_SWAP;
				end else begin
					count_next = count_reg - 4'h1;
				end
			end
			SEQ_SWAP: begin
				active_next = target_reg;
				count_next  = ccs_pkg::GATE_QUIET_COUNT;
				state_next  = SEQ_RESUME;
			end
			SEQ_RESUME: begin
				if (count_reg <= 4'h1) begin
					gate_next  = 1'b1;
					done_next  = 1'b1;
					state_next = SEQ_IDLE;
				end else begin
					count_next = count_reg - 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg  <= SEQ_IDLE;
			active_reg <= ccs_pkg::SEL_RESET;
			target_reg <= ccs_pkg::SEL_RESET;
			count_reg  <= 4'h0;
			gate_reg   <= 1'b0;
			done_reg   <= 1'b0;
		end else begin
			state_reg  <= state_next;
			active_reg <= active_next;
			target_reg <= target_next;
			count_reg  <= count_next;
			gate_reg   <= gate_next;
			done_reg   <= done_next;
		end
	end

	assign o_active      = active_reg;
	assign o_gate_enable = gate_reg;
	assign o_busy        = (state_reg != SEQ_IDLE);
	assign o_done        = done_reg;

endmodule

// file: rtl/ccs_regs.sv
// clock source switch registers with apb slave
//
// Functional notes
// - source codes select oscillator and pll
// - codes 011 and 000 act as 110
// - reserved source write changes nothing
// - divider ratio is two to code
// - source request loads from reset fuse
// - fuse zero makes request read only
// - divider resets 0010 for source 110
// - current register shows active source, divider
// - current register resets like request
// - hold suspends switch, raises switch flag
// - hold clear at ready completes switch
// - secondary oscillator power bit read/write
// - switch done when request equals current
// - new ready only while switching and ready
// - per oscillator ready bits in status
// - pll ready needs enable, input, lock
// - hf source follows external frequency select
// - old source runs until new ready
// - switch updates current, clears new ready
// - divider only change is immediately ready
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module ccs_regs (
	input  wire logic           i_clock,
	input  wire logic           i_rstn,
	input  wire logic           i_psel,
	input  wire logic           i_penable,
	input  wire logic           i_pwrite,
	input  wire logic [11:0]    i_paddr,
	input  wire logic [31:0]    i_pwdata,
	input  wire logic [3:0]     i_pstrb,
	output logic [31:0]         o_prdata,
	output logic                o_pready,
	output logic                o_pslverr,
	input  wire logic [2:0]     i_reset_source_fuse,
	input  wire logic           i_switch_allowed_fuse,
	input  ccs_pkg::ccs_osc_type i_osc,
	output ccs_pkg::ccs_sel_type o_req_sel,
	output ccs_pkg::ccs_sel_type o_cur_sel,
	output logic [2:0]          o_cur_effective_source,
	output logic                o_hf_use_freq_select,
	output logic                o_pll_enable_request,
	output logic                o_secondary_osc_power,
	output logic                o_clock_gate_enable,
	output logic                o_switch_irq_flag
);

	// reserved codes fold onto hf internal
	function automatic logic [2:0] effective_source(input logic [2:0] src);
		effective_source = (src == ccs_pkg::SRC_RESERVED3 || src == ccs_pkg::SRC_RESERVED0) ?
			ccs_pkg::SRC_HF_INT : src;
	endfunction

	function automatic logic is_reserved(input logic [2:0] src);
		is_reserved = (src == ccs_pkg::SRC_RESERVED3 || src == ccs_pkg::SRC_RESERVED0);
	endfunction

	// divider reset value follows the source
	function automatic logic [3:0] reset_divider(input logic [2:0] src);
		reset_divider = (src == ccs_pkg::SRC_HF_INT) ? ccs_pkg::DIV_BY_4 : ccs_pkg::DIV_BY_1;
	endfunction

	// pll ready needs its input, enable and lock
	function automatic logic pll_ready(input ccs_pkg::ccs_osc_type osc, input logic in_ready);
		pll_ready = osc.pll_enabled && osc.pll_locked && in_ready;
	endfunction

	// readiness of the oscillator a code selects
	function automatic logic source_ready(input logic [2:0] src, input ccs_pkg::ccs_osc_type osc);
		logic r;
		r = 1'b0;
		unique case (effective_source(src))
			ccs_pkg::SRC_EXTERNAL:  r = osc.ext_ready;
			ccs_pkg::SRC_HF_INT:    r = osc.hf_ready;
			ccs_pkg::SRC_LF_INT:    r = osc.lf_ready;
			ccs_pkg::SRC_SECONDARY: r = osc.sec_ready;
			ccs_pkg::SRC_EXT_PLL:   r = pll_ready(osc, osc.ext_ready);
			ccs_pkg::SRC_HF_PLL:    r = pll_ready(osc, osc.hf_ready);
			default:                r = osc.hf_ready;
		endcase
		source_ready = r;
	endfunction

	function automatic logic uses_pll(input logic [2:0] src);
		uses_pll = (src == ccs_pkg::SRC_EXT_PLL || src == ccs_pkg::SRC_HF_PLL);
	endfunction

	function automatic logic [31:0] sel_word(input ccs_pkg::ccs_sel_type s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[ccs_pkg::SOURCE_MSB:ccs_pkg::SOURCE_LSB]   = s.source;
		w[ccs_pkg::DIVIDER_MSB:ccs_pkg::DIVIDER_LSB] = s.divider;
		sel_word = w;
	endfunction

	function automatic ccs_pkg::ccs_sel_type sel_of_word(input logic [31:0] w);
		ccs_pkg::ccs_sel_type s;
		s.source  = w[ccs_pkg::SOURCE_MSB:ccs_pkg::SOURCE_LSB];
		s.divider = w[ccs_pkg::DIVIDER_MSB:ccs_pkg::DIVIDER_LSB];
		sel_of_word = s;
	endfunction

	// apb address decode
	function automatic logic is_mapped(input logic [11:0] addr);
		is_mapped = (addr == ccs_pkg::REQUEST_ADDR) || (addr == ccs_pkg::CURRENT_ADDR) ||
			(addr == ccs_pkg::CONTROL_ADDR) || (addr == ccs_pkg::STATUS_ADDR);
	endfunction

	// pll input taken from the external oscillator only for code 010
	function automatic logic pll_input_ready(input logic [2:0] src, input ccs_pkg::ccs_osc_type osc);
		pll_input_ready = (src == ccs_pkg::SRC_EXT_PLL) ? osc.ext_ready : osc.hf_ready;
	endfunction

	ccs_pkg::ccs_sel_type req_reg;
	ccs_pkg::ccs_sel_type req_next;
	ccs_pkg::ccs_sel_type fuse_sel;
	ccs_pkg::ccs_sel_type cur_sel;
	ccs_pkg::ccs_sel_type wr_sel;
	logic                 loaded_reg;
	logic                 loaded_next;
	logic                 allow_reg;
	logic                 allow_next;
	logic                 hold_reg;
	logic                 hold_next;
	logic                 sec_pwr_reg;
	logic                 sec_pwr_next;
	logic                 new_rdy_reg;
	logic                 new_rdy_next;
	logic                 irq_reg;
	logic                 irq_next;
	logic [31:0]          rdata_reg;
	logic [31:0]          rdata_next;
	logic                 err_reg;
	logic                 err_next;
	logic                 setup;
	logic                 access;
	logic                 wr_req;
	logic                 wr_ctl;
	logic                 mapped;
	logic                 pending;
	logic                 req_ready;
	logic                 start;
	logic                 seq_busy;
	logic                 seq_done;
	logic                 gate_en;
	logic                 do_load;
	logic [7:0]           ctl_byte;
	logic [7:0]           stat_byte;

	assign setup   = i_psel && !i_penable;
	assign access  = i_psel && i_penable;
	assign mapped  = is_mapped(i_paddr);
	assign wr_req  = access && i_pwrite && i_pstrb[0] && (i_paddr == ccs_pkg::REQUEST_ADDR);
	assign wr_ctl  = access && i_pwrite && i_pstrb[0] && (i_paddr == ccs_pkg::CONTROL_ADDR);
	assign do_load = !loaded_reg;

	// fuse caught on first edge after release
	always_comb begin
		fuse_sel.source  = i_reset_source_fuse;
		fuse_sel.divider = reset_divider(i_reset_source_fuse);
		wr_sel           = sel_of_word(i_pwdata);
	end

	// request register and fuse capture
	always_comb begin
		req_next    = req_reg;
		loaded_next = 1'b1;
		allow_next  = allow_reg;
		if (do_load) begin
			req_next   = fuse_sel;
			allow_next = i_switch_allowed_fuse;
		end else if (wr_req && allow_reg && !is_reserved(wr_sel.source)) begin
			req_next = wr_sel;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			req_reg    <= ccs_pkg::SEL_RESET;
			loaded_reg <= 1'b0;
			allow_reg  <= 1'b0;
		end else begin
			req_reg    <= req_next;
			loaded_reg <= loaded_next;
			allow_reg  <= allow_next;
		end
	end

	// switch pending while request differs
	// a started swap runs to its end; a newer request waits for it
	assign pending = loaded_reg && (req_reg != cur_sel) && !seq_busy;

	assign req_ready = (req_reg.source == cur_sel.source) || source_ready(req_reg.source, i_osc);

	// start only when hold is clear
	// readiness rechecked so a fresh request cannot swap early
	assign start = new_rdy_reg && req_ready && !hold_reg && pending;

	// software control bits
	always_comb begin
		hold_next    = hold_reg;
		sec_pwr_next = sec_pwr_reg;
		if (wr_ctl) begin
			hold_next    = i_pwdata[ccs_pkg::HOLD_BIT];
			sec_pwr_next = i_pwdata[ccs_pkg::SEC_PWR_BIT];
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			hold_reg    <= ccs_pkg::HOLD_RESET;
			sec_pwr_reg <= ccs_pkg::SEC_PWR_RESET;
		end else begin
			hold_reg    <= hold_next;
			sec_pwr_reg <= sec_pwr_next;
		end
	end

	// switch event flags
	always_comb begin
		new_rdy_next = new_rdy_reg;
		irq_next     = 1'b0;
		if (!pending && !seq_busy) begin
			new_rdy_next = 1'b0;
		end
		// request moved to an oscillator not yet ready
		if (pending && !req_ready) begin
			new_rdy_next = 1'b0;
		end
		if (seq_done) begin
			new_rdy_next = 1'b0;
		end
		// ready flag with switch flag, set wins
		if (pending && req_ready && !new_rdy_reg) begin
			new_rdy_next = 1'b1;
			irq_next     = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			new_rdy_reg <= 1'b0;
			irq_reg     <= 1'b0;
		end else begin
			new_rdy_reg <= new_rdy_next;
			irq_reg     <= irq_next;
		end
	end

	ccs_switch_seq u_seq (
		.i_clock       (i_clock),
		.i_rstn        (i_rstn),
		.i_load        (do_load),
		.i_load_value  (fuse_sel),
		.i_start       (start),
		.i_target      (req_reg),
		.o_active      (cur_sel),
		.o_gate_enable (gate_en),
		.o_busy        (seq_busy),
		.o_done        (seq_done)
	);

	// control register image
	always_comb begin
		ctl_byte = 8'h00;
		ctl_byte[ccs_pkg::HOLD_BIT]    = hold_reg;
		ctl_byte[ccs_pkg::SEC_PWR_BIT] = sec_pwr_reg;
		// done only when nothing is moving
		ctl_byte[ccs_pkg::DONE_BIT]    = loaded_reg && (req_reg == cur_sel) && !seq_busy;
		ctl_byte[ccs_pkg::NEW_RDY_BIT] = new_rdy_reg;
	end

	// status register image
	always_comb begin
		stat_byte = 8'h00;
		stat_byte[ccs_pkg::EXT_RDY_BIT] = i_osc.ext_ready;
		stat_byte[ccs_pkg::HF_RDY_BIT]  = i_osc.hf_ready;
		stat_byte[ccs_pkg::MF_RDY_BIT]  = i_osc.mf_ready;
		stat_byte[ccs_pkg::LF_RDY_BIT]  = i_osc.lf_ready;
		stat_byte[ccs_pkg::SEC_RDY_BIT] = i_osc.sec_ready;
		stat_byte[ccs_pkg::ADC_RDY_BIT] = i_osc.adc_ready;
		stat_byte[ccs_pkg::PLL_RDY_BIT] = pll_ready(i_osc, pll_input_ready(cur_sel.source, i_osc));
	end

	// read data latched in setup, answered in access
	always_comb begin
		rdata_next = rdata_reg;
		err_next   = err_reg;
		if (setup) begin
			err_next   = !mapped;
			rdata_next = 32'h0000_0000;
			unique case (i_paddr)
				// bit 7 of both reads zero
				ccs_pkg::REQUEST_ADDR: rdata_next = sel_word(req_reg);
				ccs_pkg::CURRENT_ADDR: rdata_next = sel_word(cur_sel);
				ccs_pkg::CONTROL_ADDR: rdata_next = {24'h00_0000, ctl_byte};
				ccs_pkg::STATUS_ADDR:  rdata_next = {24'h00_0000, stat_byte};
				default:               rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_reg <= 32'h0000_0000;
			err_reg   <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			err_reg   <= err_next;
		end
	end

	// no wait states: read data was latched in setup
	assign o_prdata  = rdata_reg;
	assign o_pready  = access;
	assign o_pslverr = access && err_reg;

	// divider code drives the postscaler as two to the code
	assign o_req_sel              = req_reg;
	assign o_cur_sel              = cur_sel;
	assign o_cur_effective_source = effective_source(cur_sel.source);
	// hf frequency comes from outside select field
	assign o_hf_use_freq_select   = (effective_source(cur_sel.source) == ccs_pkg::SRC_HF_INT) ||
		(cur_sel.source == ccs_pkg::SRC_HF_PLL);
	// pll kept up for current or requested use
	assign o_pll_enable_request   = uses_pll(cur_sel.source) || uses_pll(req_reg.source);
	assign o_secondary_osc_power  = sec_pwr_reg;
	assign o_clock_gate_enable    = gate_en;
	assign o_switch_irq_flag      = irq_reg;

endmodule

// file: dv/ccs_regs_checker.sv
// concurrent checks on the ports of the clock source switch registers
`timescale 1ns/1ps
module ccs_regs_checker (
	input  wire logic            i_clock,
	input  wire logic            i_rstn,
	input  wire logic            i_psel,
	input  wire logic            i_penable,
	input  wire logic            i_pwrite,
	input  wire logic [11:0]     i_paddr,
	input  wire logic [31:0]     i_pwdata,
	input  wire logic [3:0]      i_pstrb,
	input  wire logic [31:0]     o_prdata,
	input  wire logic            o_pready,
	input  wire logic            o_pslverr,
	input  ccs_pkg::ccs_sel_type o_req_sel,
	input  ccs_pkg::ccs_sel_type o_cur_sel,
	input  wire logic [2:0]      o_cur_effective_source,
	input  wire logic            o_hf_use_freq_select,
	input  wire logic            o_pll_enable_request,
	input  wire logic            o_clock_gate_enable,
	input  wire logic            o_switch_irq_flag
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);

	logic       acc;
	logic       req_wr;
	logic [2:0] eff;
	assign acc = i_psel & i_penable;
	assign req_wr = acc & i_pwrite & i_pstrb[0] & (i_paddr == ccs_pkg::REQUEST_ADDR);
	assign eff = (o_cur_sel.source == 3'h3 || o_cur_sel.source == 3'h0) ? 3'h6 : o_cur_sel.source;

	pready_match_a: assert property (o_pready == acc) else $error("pready not equal to access phase");
	slverr_map_a: assert property (acc |-> o_pslverr == !(i_paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
		else $error("pslverr does not match address map");
	upper_zero_a: assert property (acc && !i_pwrite |-> o_prdata[31:8] == 24'h0 &&
		!(o_prdata[7] && i_paddr inside {12'h000, 12'h004})) else $error("unused read bits not zero");
	eff_source_a: assert property (o_cur_effective_source == eff) else $error("effective source wrong");
	hf_follow_a: assert property (o_hf_use_freq_select == (eff == 3'h6 || o_cur_sel.source == 3'h1))
		else $error("hf frequency select use wrong");
	pll_request_a: assert property (o_pll_enable_request == (o_cur_sel.source inside {3'h2, 3'h1} ||
		o_req_sel.source inside {3'h2, 3'h1})) else $error("pll enable request wrong");
	rsv_write_a: assert property (req_wr && i_pwdata[6:4] inside {3'h3, 3'h0} |=> $stable(o_req_sel))
		else $error("reserved source write changed request");
	swap_gated_a: assert property ($changed(o_cur_sel) |-> !$past(o_clock_gate_enable))
		else $error("selection changed with clock running");
	gate_quiet_a: assert property ($fell(o_clock_gate_enable) |-> !o_clock_gate_enable [*2])
		else $error("clock gate quiet time too short");
	irq_pulse_a: assert property (o_switch_irq_flag |=> !o_switch_irq_flag)
		else $error("switch flag longer than one cycle");

	irq_seen_c: cover property (o_switch_irq_flag);
	rsv_seen_c: cover property (req_wr && i_pwdata[6:4] == 3'h3);
	swap_seen_c: cover property ($fell(o_clock_gate_enable));
endmodule

bind ccs_regs ccs_regs_checker u_ccs_regs_checker (.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_req_sel(o_req_sel),
	.o_cur_sel(o_cur_sel), .o_cur_effective_source(o_cur_effective_source),
	.o_hf_use_freq_select(o_hf_use_freq_select), .o_pll_enable_request(o_pll_enable_request),
	.o_clock_gate_enable(o_clock_gate_enable), .o_switch_irq_flag(o_switch_irq_flag));

// file: dv/ccs_regs_tb.sv
// self-checking bench for the clock source switch registers
`timescale 1ns/1ps
module ccs_regs_tb;
	logic                 i_clock;
	logic                 i_rstn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [11:0]          paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic [31:0]          rd;
	logic [3:0]           pstrb;
	logic [2:0]           fuse_src;
	logic                 fuse_allow;
	logic                 pready;
	logic                 pslverr;
	logic                 rerr;
	logic                 sec_pwr;
	logic                 irq;
	logic [2:0]           eff_src;
	logic                 hf_sel;
	ccs_pkg::ccs_osc_type osc;
	int                   err_count;
	int                   compares;
	int                   irq_seen;
	int                   n0;
	logic [7:0]           rows [10][2] = '{'{8'h70, 8'h70}, '{8'h51, 8'h51}, '{8'h49, 8'h49}, '{8'h22, 8'h22},
		'{8'h13, 8'h13}, '{8'h64, 8'h64}, '{8'h3f, 8'h64}, '{8'h05, 8'h64}, '{8'h6a, 8'h6a}, '{8'hff, 8'h7f}};
	logic [7:0]           stat [4][2] = '{'{8'hff, 8'hfd}, '{8'hab, 8'ha8}, '{8'h57, 8'h55}, '{8'h7e, 8'h7c}};

	ccs_regs u_ccs_regs (.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_reset_source_fuse(fuse_src), .i_switch_allowed_fuse(fuse_allow), .i_osc(osc),
		.o_req_sel(), .o_cur_sel(), .o_cur_effective_source(eff_src), .o_hf_use_freq_select(hf_sel),
		.o_pll_enable_request(), .o_secondary_osc_power(sec_pwr), .o_clock_gate_enable(),
		.o_switch_irq_flag(irq));

	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end

	// flag is registered, so count it away from the launching edge
	always @(negedge i_clock) begin
		if (irq === 1'b1)
			irq_seen <= irq_seen + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		do begin
			@(posedge i_clock);
		end while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		do begin
			apb(1'b0, ccs_pkg::CONTROL_ADDR, 32'h0);
			n++;
		end while (rd[ccs_pkg::DONE_BIT] !== 1'b1 && n < 30);
		chk({31'h0, rd[ccs_pkg::DONE_BIT]}, 32'h1);
	endtask

	task automatic do_reset(input logic [2:0] s, input logic a);
		@(posedge i_clock);
		i_rstn <= 1'b0;
		fuse_src <= s;
		fuse_allow <= a;
		repeat (8) @(posedge i_clock);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clock);
	endtask

	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_clock);
		err_count++;
		close_out();
	end

	initial begin
		{i_rstn, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h0, 12'h0, 32'h0, 4'hf};
		{fuse_src, fuse_allow, osc, err_count, compares, irq_seen} = {3'h6, 1'b1, 8'hff, 96'h0};
		do_reset(ccs_pkg::SRC_HF_INT, 1'b1);
		rd_chk(ccs_pkg::REQUEST_ADDR, 32'h62);
		rd_chk(ccs_pkg::CURRENT_ADDR, 32'h62);
		rd_chk(ccs_pkg::CONTROL_ADDR, 32'h10);
		for (int i = 0; i < 10; i++) begin
			apb(1'b1, ccs_pkg::REQUEST_ADDR, {24'h0, rows[i][0]});
			wait_done();
			rd_chk(ccs_pkg::REQUEST_ADDR, {24'h0, rows[i][1]});
			rd_chk(ccs_pkg::CURRENT_ADDR, {24'h0, rows[i][1]});
		end
		for (int i = 0; i < 4; i++) begin
			osc <= stat[i][0];
			rd_chk(ccs_pkg::STATUS_ADDR, {24'h0, stat[i][1]});
		end
		// held switch, abandon, then release
		osc <= '1;
		apb(1'b1, ccs_pkg::CONTROL_ADDR, 32'h80);
		n0 = irq_seen;
		apb(1'b1, ccs_pkg::REQUEST_ADDR, 32'h50);
		repeat (8) @(posedge i_clock);
		rd_chk(ccs_pkg::CONTROL_ADDR, 32'h88);
		chk(32'(irq_seen - n0), 32'h1);
		rd_chk(ccs_pkg::CURRENT_ADDR, 32'h7f);
		apb(1'b1, ccs_pkg::REQUEST_ADDR, 32'h7f);
		rd_chk(ccs_pkg::CONTROL_ADDR, 32'h90);
		apb(1'b1, ccs_pkg::REQUEST_ADDR, 32'h50);
		repeat (4) @(posedge i_clock);
		apb(1'b1, ccs_pkg::CONTROL_ADDR, 32'h00);
		wait_done();
		rd_chk(ccs_pkg::CURRENT_ADDR, 32'h50);
		// new source not ready yet: old one keeps running
		osc <= '0;
		apb(1'b1, ccs_pkg::REQUEST_ADDR, 32'h40);
		repeat (10) @(posedge i_clock);
		rd_chk(ccs_pkg::CONTROL_ADDR, 32'h00);
		rd_chk(ccs_pkg::CURRENT_ADDR, 32'h50);
		osc <= 8'h08;
		wait_done();
		rd_chk(ccs_pkg::CURRENT_ADDR, 32'h40);
		osc <= '0;
		apb(1'b1, ccs_pkg::REQUEST_ADDR, 32'h45);
		wait_done();
		rd_chk(ccs_pkg::CURRENT_ADDR, 32'h45);
		apb(1'b1, ccs_pkg::CONTROL_ADDR, 32'h40);
		rd_chk(ccs_pkg::CONTROL_ADDR, 32'h50);
		chk({31'h0, sec_pwr}, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rd, 32'h0);
		pstrb <= 4'h0;
		apb(1'b1, ccs_pkg::REQUEST_ADDR, 32'h70);
		pstrb <= 4'hf;
		apb(1'b1, ccs_pkg::CURRENT_ADDR, 32'h70);
		rd_chk(ccs_pkg::REQUEST_ADDR, 32'h45);
		rd_chk(ccs_pkg::CURRENT_ADDR, 32'h45);
		do_reset(ccs_pkg::SRC_LF_INT, 1'b0);
		rd_chk(ccs_pkg::REQUEST_ADDR, 32'h50);
		apb(1'b1, ccs_pkg::REQUEST_ADDR, 32'h70);
		rd_chk(ccs_pkg::REQUEST_ADDR, 32'h50);
		rd_chk(ccs_pkg::CONTROL_ADDR, 32'h10);
		do_reset(ccs_pkg::SRC_RESERVED0, 1'b1);
		rd_chk(ccs_pkg::REQUEST_ADDR, 32'h00);
		chk({29'h0, eff_src}, 32'h6);
		chk({31'h0, hf_sel}, 32'h1);
		close_out();
	end
endmodule
